// ===== shared/txr_pkg.sv
// constants and types shared by the trap/xor/round-load execution unit
`default_nettype none
package txr_pkg;
  // program flow
  localparam logic [15:0] TRAP_VECTOR = 16'h0022;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP_LONG = 16'h0002;
  // data path constants
  localparam logic [15:0] ROUND_HALF = 16'h8000;
  localparam logic [4:0] LK16_SHIFT = 5'h10;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  // extra cycles after the accept cycle, and the wait count of the last wait cycle
  localparam logic [1:0] TRAP_XTRA = 2'h3;
  localparam logic [1:0] LK_XTRA = 2'h1;
  localparam logic [1:0] WAIT_LAST = 2'h1;
  // decoded commands
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_TRAP = 3'h1,
    CMD_XOR_MEM = 3'h2,
    CMD_XOR_LK = 3'h3,
    CMD_XOR_LK16 = 3'h4,
    CMD_ROUND_LOAD = 3'h5,
    CMD_TABLE_WRITE = 3'h6,
    CMD_RET = 3'h7
  } txr_cmd_t;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD = 4'h1,
    ST_WAIT = 4'h2,
    ST_TW_XFER = 4'h3,
    ST_TW_DONE = 4'h4,
    ST_EX_ISSUE = 4'h5,
    ST_EX_RD = 4'h6,
    ST_EX_WRI = 4'h7,
    ST_EX_WR = 4'h8
  } txr_state_t;
endpackage
`default_nettype wire

// ===== verilog/txr_alu.sv
// accumulator result for xor and round-load forms
`default_nettype none
module txr_alu
  import txr_pkg::*;
(
  // operation and operands
  input wire txr_cmd_t op_i,
  input wire logic [31:0] acc_i,
  input wire logic [15:0] mem_i,
  input wire logic [15:0] lk_i,
  input wire logic [3:0] shift_i,
  // result
  output logic [31:0] res_o
);
  // zero-filled on both ends, so no sign bits leak upward
  function automatic logic [31:0] place_lk(input logic [15:0] lk,
                                           input logic [4:0] sh);
    place_lk = {ZERO_HALF, lk} << sh;
  endfunction

  // result select; carry is never touched here
  always_comb
  begin
    case (op_i)
      CMD_XOR_MEM: res_o = {acc_i[31:16], acc_i[15:0] ^ mem_i};
      CMD_XOR_LK: res_o = acc_i ^ place_lk(lk_i, {1'b0, shift_i});
      CMD_XOR_LK16: res_o = acc_i ^ place_lk(lk_i, LK16_SHIFT);
      CMD_ROUND_LOAD: res_o = {mem_i, ROUND_HALF};
      default: res_o = acc_i;
    endcase
  end
endmodule
`default_nettype wire

// ===== verilog/txr_stack.sv
// hardware return stack, push shifts down, pop shifts up
`default_nettype none
module txr_stack #(
  parameter int DEPTH = 8,
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // stack control
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] top_o
);
  logic [W-1:0] ent_reg [DEPTH];
  logic [W-1:0] ent_next [DEPTH];

  // overflow drops the deepest entry, underflow repeats it
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    if (i == 0)
    begin : g_top
      always_comb
      begin
        ent_next[i] = ent_reg[i];
        if (push_i)
          ent_next[i] = din_i;
        else if (pop_i)
          ent_next[i] = (DEPTH > 1) ? ent_reg[(DEPTH > 1) ? 1 : 0] : ent_reg[i];
      end
    end
    else
    begin : g_rest
      always_comb
      begin
        ent_next[i] = ent_reg[i];
        if (push_i)
          ent_next[i] = ent_reg[i-1];
        else if (pop_i && i < DEPTH - 1)
          ent_next[i] = ent_reg[(i < DEPTH - 1) ? i + 1 : i];
      end
    end
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        ent_reg[i] <= '0;
      else
        ent_reg[i] <= ent_next[i];
    end
  end

  assign top_o = ent_reg[0];
endmodule
`default_nettype wire

// ===== verilog/txr_exec_unit.sv
// execution unit for trap, xor, round-load and repeated table write
// Functional notes
// - trap fetches next instruction from 22h
// - trap pushes program counter plus one
// - trap is non-maskable, always taken
// - trap ignores and keeps global interrupt mask
// - memory xor changes only accumulator low half
// - immediate xor shifts constant, zero-fills, whole accumulator
// - immediate shift range 0 to 15, default zero
// - separate immediate xor with fixed shift sixteen
// - xor never changes carry flag
// - round-load: word high, 8000h low
// - direct address uses seven low instruction bits
// - indirect operand selects next auxiliary register
// - on-chip repeated table write takes n+2 cycles
// - external repeated table write takes 4n plus waits
// - table write reads data, writes at accumulator low
`default_nettype none
module txr_exec_unit
  import txr_pkg::*;
#(
  parameter int RPT_W = 8,
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // decoded command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire txr_cmd_t cmd_i,
  input wire logic ind_i,
  input wire logic [6:0] dma_i,
  input wire logic [8:0] dp_i,
  input wire logic [15:0] ar_addr_i,
  input wire logic nar_valid_i,
  input wire logic [2:0] nar_i,
  input wire logic [3:0] shift_i,
  input wire logic [15:0] lk_i,
  input wire logic [RPT_W-1:0] rpt_i,
  input wire logic tw_ext_i,
  // data memory read
  output logic dmem_rd_o,
  output logic [15:0] dmem_addr_o,
  input wire logic [15:0] dmem_rdata_i,
  input wire logic dmem_ready_i,
  output logic ar_step_o,
  // program memory write
  output logic pmem_wr_o,
  output logic [15:0] pmem_addr_o,
  output logic [15:0] pmem_wdata_o,
  input wire logic pmem_ready_i,
  // status loads from other instructions
  input wire logic mask_wr_i,
  input wire logic mask_val_i,
  input wire logic carry_wr_i,
  input wire logic carry_val_i,
  // architectural state
  output logic [31:0] acc_o,
  output logic [15:0] pc_o,
  output logic [2:0] aux_register_pointer_o,
  output logic global_interrupt_mask_o,
  output logic carry_o
);
  txr_state_t state_reg, state_next;
  txr_cmd_t op_reg, op_next, alu_op;
  logic [31:0] accumulator_reg, accumulator_next, alu_res;
  logic [15:0] pc_reg, pc_next, mstack_reg, mstack_next;
  logic [15:0] daddr_reg, daddr_next, buf_reg, buf_next;
  logic [2:0] aux_register_pointer_reg, aux_register_pointer_next;
  logic global_interrupt_mask_reg, global_interrupt_mask_next;
  logic carry_reg, carry_next, ind_reg, ind_next;
  logic [RPT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] wait_reg, wait_next;
  logic accept, stk_push, stk_pop;
  logic [15:0] stk_top;

  assign accept = cmd_valid_i && (state_reg == ST_IDLE);
  // lk and shift are only meaningful in the accept cycle
  assign alu_op = (state_reg == ST_IDLE) ? cmd_i : op_reg;

  txr_alu u_alu (
    .op_i(alu_op),
    .acc_i(accumulator_reg),
    .mem_i(dmem_rdata_i),
    .lk_i(lk_i),
    .shift_i(shift_i),
    .res_o(alu_res)
  );

  txr_stack #(.DEPTH(STACK_DEPTH), .W(16)) u_stack (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_i(stk_push),
    .pop_i(stk_pop),
    .din_i(pc_reg + PC_STEP),
    .top_o(stk_top)
  );

  // sequencer and architectural next state
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    accumulator_next = accumulator_reg;
    pc_next = pc_reg;
    mstack_next = mstack_reg;
    daddr_next = daddr_reg;
    buf_next = buf_reg;
    aux_register_pointer_next = aux_register_pointer_reg;
    global_interrupt_mask_next = global_interrupt_mask_reg;
    carry_next = carry_reg;
    ind_next = ind_reg;
    cnt_next = cnt_reg;
    wait_next = wait_reg;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    ar_step_o = 1'b0;
    // status loads come only from other instructions
    if (mask_wr_i)
      global_interrupt_mask_next = mask_val_i;
    if (carry_wr_i)
      carry_next = carry_val_i;
    case (state_reg)
      ST_IDLE:
        if (cmd_valid_i)
        begin
          op_next = cmd_i;
          ind_next = ind_i;
          // page bits above the seven instruction bits
          daddr_next = ind_i ? ar_addr_i : {dp_i, dma_i};
          if (ind_i && nar_valid_i)
            aux_register_pointer_next = nar_i;
          pc_next = pc_reg + PC_STEP;
          case (cmd_i)
            CMD_TRAP:
            begin
              // no mask term: the mask bit is never consulted
              stk_push = 1'b1;
              pc_next = TRAP_VECTOR;
              wait_next = TRAP_XTRA;
              state_next = ST_WAIT;
            end
            CMD_XOR_MEM, CMD_ROUND_LOAD:
              state_next = ST_RD;
            CMD_XOR_LK, CMD_XOR_LK16:
            begin
              accumulator_next = alu_res;
              pc_next = pc_reg + PC_STEP_LONG;
              wait_next = LK_XTRA;
              state_next = ST_WAIT;
            end
            CMD_TABLE_WRITE:
            begin
              // pc steps through program memory, return kept aside
              mstack_next = pc_reg + PC_STEP;
              pc_next = accumulator_reg[15:0];
              cnt_next = rpt_i;
              state_next = tw_ext_i ? ST_EX_RD : ST_TW_XFER;
            end
            CMD_RET:
            begin
              stk_pop = 1'b1;
              pc_next = stk_top;
            end
            default: ;
          endcase
        end
      ST_RD:
        if (dmem_ready_i)
        begin
          accumulator_next = alu_res;
          ar_step_o = ind_reg;
          state_next = ST_IDLE;
        end
      ST_WAIT:
      begin
        wait_next = wait_reg - WAIT_LAST;
        if (wait_reg == WAIT_LAST)
          state_next = ST_IDLE;
      end
      ST_TW_XFER:
      begin
        // on-chip: read and write in the same cycle
        pc_next = pc_reg + PC_STEP;
        ar_step_o = ind_reg;
        if (ind_reg)
          daddr_next = ar_addr_i;
        if (cnt_reg == '0)
          state_next = ST_TW_DONE;
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_TW_DONE:
      begin
        pc_next = mstack_reg;
        state_next = ST_IDLE;
      end
      ST_EX_ISSUE:
        state_next = ST_EX_RD;
      ST_EX_RD:
        // read first, waits stretch this phase
        if (dmem_ready_i)
        begin
          buf_next = dmem_rdata_i;
          state_next = ST_EX_WRI;
        end
      ST_EX_WRI:
        state_next = ST_EX_WR;
      ST_EX_WR:
        if (pmem_ready_i)
        begin
          ar_step_o = ind_reg;
          if (ind_reg)
            daddr_next = ar_addr_i;
          if (cnt_reg == '0)
          begin
            pc_next = mstack_reg;
            state_next = ST_IDLE;
          end
          else
          begin
            pc_next = pc_reg + PC_STEP;
            cnt_next = cnt_reg - 1'b1;
            state_next = ST_EX_ISSUE;
          end
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      op_reg <= CMD_NOP;
      accumulator_reg <= '0;
      pc_reg <= '0;
      mstack_reg <= '0;
      daddr_reg <= '0;
      buf_reg <= '0;
      aux_register_pointer_reg <= '0;
      global_interrupt_mask_reg <= 1'b1;
      carry_reg <= 1'b0;
      ind_reg <= 1'b0;
      cnt_reg <= '0;
      wait_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      accumulator_reg <= accumulator_next;
      pc_reg <= pc_next;
      mstack_reg <= mstack_next;
      daddr_reg <= daddr_next;
      buf_reg <= buf_next;
      aux_register_pointer_reg <= aux_register_pointer_next;
      global_interrupt_mask_reg <= global_interrupt_mask_next;
      carry_reg <= carry_next;
      ind_reg <= ind_next;
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
    end
  end

  // memory strobes decode from the registered state
  assign cmd_ready_o = (state_reg == ST_IDLE);
  assign dmem_rd_o = (state_reg == ST_RD) || (state_reg == ST_TW_XFER) ||
                     (state_reg == ST_EX_RD);
  assign dmem_addr_o = daddr_reg;
  assign pmem_wr_o = (state_reg == ST_TW_XFER) || (state_reg == ST_EX_WR);
  assign pmem_addr_o = pc_reg;
  // on-chip path forwards the read word, external path the captured one
  assign pmem_wdata_o = (state_reg == ST_EX_WR) ? buf_reg : dmem_rdata_i;
  assign acc_o = accumulator_reg;
  assign pc_o = pc_reg;
  assign aux_register_pointer_o = aux_register_pointer_reg;
  assign global_interrupt_mask_o = global_interrupt_mask_reg;
  assign carry_o = carry_reg;

  // cycle counters watched only by the checks below
  logic [RPT_W+1:0] tw_cyc_reg;
  logic [RPT_W+2:0] ex_cyc_reg;
  logic [RPT_W-1:0] rpt_reg;
  logic ex_stall;
  assign ex_stall = (state_reg == ST_EX_RD && !dmem_ready_i) ||
                    (state_reg == ST_EX_WR && !pmem_ready_i);
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tw_cyc_reg <= '0;
      ex_cyc_reg <= '0;
      rpt_reg <= '0;
    end
    else if (accept)
    begin
      tw_cyc_reg <= (RPT_W+2)'(1);
      ex_cyc_reg <= (RPT_W+3)'(1);
      rpt_reg <= rpt_i;
    end
    else
    begin
      tw_cyc_reg <= tw_cyc_reg + 1'b1;
      if (!ex_stall)
        ex_cyc_reg <= ex_cyc_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_TRAP_VECTOR: assert property (
    accept && cmd_i == CMD_TRAP |=> pc_o == TRAP_VECTOR)
    else $error("trap did not load vector");
  AST_TRAP_PUSH: assert property (
    accept && cmd_i == CMD_TRAP |=> stk_top == $past(pc_reg) + PC_STEP)
    else $error("trap pushed wrong return address");
  AST_TRAP_MASKED: assert property (
    accept && cmd_i == CMD_TRAP && global_interrupt_mask_o
    |=> state_reg == ST_WAIT ##3 state_reg == ST_IDLE)
    else $error("masked trap not taken in four cycles");
  AST_TRAP_MASK_KEPT: assert property (
    accept && cmd_i == CMD_TRAP && !mask_wr_i
    |=> global_interrupt_mask_o == $past(global_interrupt_mask_o))
    else $error("trap changed interrupt mask");
  AST_XOR_LOW: assert property (
    state_reg == ST_RD && op_reg == CMD_XOR_MEM && dmem_ready_i
    |=> acc_o[31:16] == $past(acc_o[31:16]) &&
        acc_o[15:0] == $past(acc_o[15:0] ^ dmem_rdata_i))
    else $error("memory xor result wrong");
  AST_XOR_SHIFT: assert property (
    accept && cmd_i == CMD_XOR_LK
    |=> acc_o == $past(acc_o ^ ({ZERO_HALF, lk_i} << shift_i)))
    else $error("shifted immediate xor wrong");
  AST_XOR_16: assert property (
    accept && cmd_i == CMD_XOR_LK16
    |=> acc_o == $past(acc_o ^ {lk_i, ZERO_HALF}))
    else $error("shift sixteen xor wrong");
  AST_CARRY_KEPT: assert property (
    !carry_wr_i |=> carry_o == $past(carry_o))
    else $error("carry changed without a load");
  AST_ROUND_LOAD: assert property (
    state_reg == ST_RD && op_reg == CMD_ROUND_LOAD && dmem_ready_i
    |=> acc_o == {$past(dmem_rdata_i), ROUND_HALF})
    else $error("round load result wrong");
  AST_DIRECT_ADDR: assert property (
    accept && !ind_i |=> dmem_addr_o == {$past(dp_i), $past(dma_i)})
    else $error("direct address not from low seven bits");
  AST_NEXT_AUX: assert property (
    accept && ind_i && nar_valid_i
    |=> aux_register_pointer_o == $past(nar_i))
    else $error("next auxiliary register not selected");
  AST_TW_ONCHIP: assert property (
    state_reg == ST_TW_DONE
    |-> tw_cyc_reg == (RPT_W+2)'(rpt_reg) + (RPT_W+2)'(2))
    else $error("on-chip table write not n+2 cycles");
  AST_TW_EXT: assert property (
    state_reg == ST_EX_WR && pmem_ready_i && cnt_reg == '0
    |-> ex_cyc_reg == {1'b0, rpt_reg, 2'b11})
    else $error("external table write not 4n plus waits");
  AST_TW_ADDR: assert property (
    accept && cmd_i == CMD_TABLE_WRITE
    |=> pmem_addr_o == $past(acc_o[15:0]))
    else $error("table write address not accumulator low");

  COV_TRAP: cover property (accept && cmd_i == CMD_TRAP);
  COV_TW_REPEAT: cover property (state_reg == ST_TW_DONE && rpt_reg != '0);
  COV_TW_EXT_WAIT: cover property (state_reg == ST_EX_RD && !dmem_ready_i);
  COV_ROUND: cover property (state_reg == ST_RD && op_reg == CMD_ROUND_LOAD);
endmodule
`default_nettype wire

// ===== sim/test_txr_exec_unit.sv
// self-checking bench for the trap, xor and round-load execution unit
`default_nettype none
module test_txr_exec_unit
  import txr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // design ports
  logic clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, ind_i, nar_valid_i;
  logic tw_ext_i, dmem_rd_o, dmem_ready_i, ar_step_o, pmem_wr_o;
  logic pmem_ready_i, mask_wr_i, mask_val_i, carry_wr_i, carry_val_i;
  logic global_interrupt_mask_o, carry_o;
  txr_cmd_t cmd_i;
  logic [6:0] dma_i;
  logic [8:0] dp_i;
  logic [2:0] nar_i, aux_register_pointer_o;
  logic [3:0] shift_i;
  logic [7:0] rpt_i;
  logic [15:0] ar_addr_i, lk_i, dmem_addr_o, dmem_rdata_i;
  logic [15:0] pmem_addr_o, pmem_wdata_o, pc_o;
  logic [31:0] acc_o;
  // bench state and reference model
  int miscompares, samples_checked, cycles, steps;
  logic [31:0] seed, m_acc;
  logic [15:0] m_pc, last_rd, exp_da, exp_pa;
  logic [2:0] m_auxp;
  logic m_mask, m_carry;
  logic [15:0] stk[$];
  txr_cmd_t ops[5] = '{CMD_XOR_MEM, CMD_XOR_LK, CMD_XOR_LK16,
                       CMD_ROUND_LOAD, CMD_NOP};
  logic [7:0] reps[3] = '{8'h00, 8'h03, 8'hC8};

  txr_exec_unit #(.RPT_W(8), .STACK_DEPTH(8)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .ind_i(ind_i),
    .dma_i(dma_i), .dp_i(dp_i), .ar_addr_i(ar_addr_i),
    .nar_valid_i(nar_valid_i), .nar_i(nar_i), .shift_i(shift_i),
    .lk_i(lk_i), .rpt_i(rpt_i), .tw_ext_i(tw_ext_i),
    .dmem_rd_o(dmem_rd_o), .dmem_addr_o(dmem_addr_o),
    .dmem_rdata_i(dmem_rdata_i), .dmem_ready_i(dmem_ready_i),
    .ar_step_o(ar_step_o), .pmem_wr_o(pmem_wr_o),
    .pmem_addr_o(pmem_addr_o), .pmem_wdata_o(pmem_wdata_o),
    .pmem_ready_i(pmem_ready_i), .mask_wr_i(mask_wr_i),
    .mask_val_i(mask_val_i), .carry_wr_i(carry_wr_i),
    .carry_val_i(carry_val_i), .acc_o(acc_o), .pc_o(pc_o),
    .aux_register_pointer_o(aux_register_pointer_o),
    .global_interrupt_mask_o(global_interrupt_mask_o),
    .carry_o(carry_o)
  );

  // 125 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // longest run is well under a thousand cycles, so this only trips on a hang
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // fixed-seed lfsr so a failing run repeats exactly
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // architectural state compare
  task automatic chk_state(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  // memory address and data compare
  task automatic chk_bus(input logic [15:0] got, input logic [15:0] exp);
    report({16'h0000, got}, {16'h0000, exp});
  endtask

  // cycle and pulse count compare
  task automatic chk_cyc(input int got, input int exp);
    report(32'(got), 32'(exp));
  endtask

  task automatic verify_state();
    chk_state(acc_o, m_acc);
    chk_state(32'(pc_o), 32'(m_pc));
    chk_state(32'(aux_register_pointer_o), 32'(m_auxp));
    chk_state(32'(global_interrupt_mask_o), 32'(m_mask));
    chk_state(32'(carry_o), 32'(m_carry));
  endtask

  // loads mask and carry as another instruction would, one cycle
  task automatic set_flags(input logic im, input logic cy);
    mask_wr_i = 1'b1;
    mask_val_i = im;
    carry_wr_i = 1'b1;
    carry_val_i = cy;
    @(negedge clk_i);
    mask_wr_i = 1'b0;
    carry_wr_i = 1'b0;
    m_mask = im;
    m_carry = cy;
  endtask

  // issue one command, serve the memories with dw/pw wait states each
  task automatic do_cmd(input txr_cmd_t c, input logic ind,
                        input logic [3:0] sh, input logic [7:0] repeat_next_instruction,
                        input logic ext, input int dw, input int pw);
    int cyc, dcnt, pcnt, n;
    logic mem;
    cyc = 0;
    dcnt = dw;
    pcnt = pw;
    steps = 0;
    n = int'(repeat_next_instruction) + 1;
    mem = (c == CMD_XOR_MEM || c == CMD_ROUND_LOAD || c == CMD_TABLE_WRITE);
    cmd_i = c;
    // only memory forms carry an indirect operand and pointer select
    ind_i = ind & mem;
    lk_i = 16'(rnd());
    shift_i = sh;
    rpt_i = repeat_next_instruction;
    tw_ext_i = ext;
    dma_i = 7'(rnd());
    dp_i = 9'(rnd());
    ar_addr_i = 16'(rnd());
    nar_valid_i = 1'(rnd());
    nar_i = 3'(rnd());
    exp_da = ind ? ar_addr_i : {dp_i, dma_i};
    exp_pa = m_acc[15:0];
    cmd_valid_i = 1'b1;
    while (cyc < 3000)
    begin
      @(posedge clk_i);
      cyc++;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      dmem_ready_i = 1'b0;
      pmem_ready_i = 1'b0;
      if (dmem_rd_o === 1'b1)
      begin
        chk_bus(dmem_addr_o, exp_da);
        dmem_ready_i = (dcnt == 0);
        dmem_rdata_i = 16'(rnd());
        dcnt = (dcnt == 0) ? dw : dcnt - 1;
        if (dmem_ready_i)
          last_rd = dmem_rdata_i;
      end
      if (pmem_wr_o === 1'b1)
      begin
        pmem_ready_i = (pcnt == 0);
        pcnt = (pcnt == 0) ? pw : pcnt - 1;
      end
      #1;
      if (ar_step_o === 1'b1)
        steps++;
      if (pmem_wr_o === 1'b1 && pmem_ready_i)
      begin
        chk_bus(pmem_addr_o, exp_pa);
        chk_bus(pmem_wdata_o, last_rd);
        exp_pa++;
      end
      if (cmd_ready_o === 1'b1)
        break;
    end
    // a command that never returns to idle is a mismatch, not a hang
    chk_state(32'(cmd_ready_o), 32'h00000001);
    // reference model update
    case (c)
      CMD_NOP: m_pc = m_pc + 16'h0001;
      CMD_TRAP:
      begin
        stk.push_back(m_pc + 16'h0001);
        m_pc = 16'h0022;
        chk_cyc(cyc, 4);
      end
      CMD_RET: m_pc = stk.pop_back();
      CMD_XOR_MEM:
      begin
        m_acc[15:0] = m_acc[15:0] ^ last_rd;
        m_pc = m_pc + 16'h0001;
      end
      CMD_XOR_LK, CMD_XOR_LK16:
      begin
        if (c == CMD_XOR_LK)
          m_acc = m_acc ^ ({16'h0000, lk_i} << sh);
        else
          m_acc = m_acc ^ {lk_i, 16'h0000};
        m_pc = m_pc + 16'h0002;
        chk_cyc(cyc, 2);
      end
      CMD_ROUND_LOAD:
      begin
        m_acc = {last_rd, 16'h8000};
        m_pc = m_pc + 16'h0001;
      end
      default:
      begin
        m_pc = m_pc + 16'h0001;
        if (ext)
          chk_cyc(cyc, 4 * n + n * dw + n * pw);
        else
          chk_cyc(cyc, n + 2);
      end
    endcase
    if (mem && ind)
    begin
      chk_cyc(steps, (c == CMD_TABLE_WRITE) ? n : 1);
      if (nar_valid_i)
        m_auxp = nar_i;
    end
    verify_state();
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rst_n_i, cmd_valid_i, ind_i, nar_valid_i, tw_ext_i} = '0;
    {dmem_ready_i, pmem_ready_i, mask_wr_i, mask_val_i} = '0;
    {carry_wr_i, carry_val_i, dma_i, dp_i, nar_i, shift_i, rpt_i} = '0;
    {ar_addr_i, lk_i, dmem_rdata_i} = '0;
    cmd_i = CMD_NOP;
    seed = 32'hBBD2;
    {m_acc, m_pc, m_auxp, m_carry, last_rd} = '0;
    m_mask = 1'b1;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    verify_state();
    set_flags(1'b1, 1'b1);
    // shift corners, then a random mix with random wait states
    do_cmd(CMD_XOR_LK, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    do_cmd(CMD_XOR_LK, 1'b0, 4'hF, 8'h00, 1'b0, 0, 0);
    do_cmd(CMD_XOR_LK16, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    repeat (60)
    begin
      set_flags(1'(rnd()), 1'(rnd()));
      do_cmd(ops[rnd() % 5], 1'(rnd()), 4'(rnd()), 8'h00, 1'b0,
             int'(rnd() % 3), 0);
    end
    // trap taken with mask set and clear, nested, then both returns
    set_flags(1'b1, 1'b0);
    do_cmd(CMD_TRAP, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    set_flags(1'b0, 1'b1);
    do_cmd(CMD_TRAP, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    do_cmd(CMD_RET, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    do_cmd(CMD_RET, 1'b0, 4'h0, 8'h00, 1'b0, 0, 0);
    // repeated table writes, on-chip and external with wait states
    foreach (reps[i])
      do_cmd(CMD_TABLE_WRITE, 1'(i), 4'h0, reps[i], 1'b0, 0, 0);
    do_cmd(CMD_TABLE_WRITE, 1'b1, 4'h0, 8'h02, 1'b1, 1, 2);
    do_cmd(CMD_TABLE_WRITE, 1'b0, 4'h0, 8'h00, 1'b1, 0, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
